// ===== cfg_loader.sv
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module cfg_loader #(
  parameter bit WAFER_PKG = 1'b0
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rstn_in,
  // avalon-mm slave
  input wire logic [23:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // nonvolatile array contents
  input wire logic [63:0] user_row_array_in,
  input wire logic [63:0] auto_cal_array_in,
  input wire logic [127:0] factory_cal_array_in,
  input wire logic [127:0] serial_array_in,
  // user row write request towards the flash controller
  output logic user_row_wr_out,
  output logic [63:0] user_row_wr_data_out,
  // load status
  output logic load_done_out,
  output logic consumer_rstn_out,
  // automatic calibration row distribution
  output logic [63:0] auto_cal_out,
  // nonvolatile controller sizing and locks
  output logic [2:0] bootloader_region_size_out,
  output logic [2:0] eeprom_size_out,
  output logic [15:0] region_lock_out,
  // supply brownout monitor
  output logic [5:0] supply_brownout_monitor_level_out,
  output logic supply_brownout_monitor_en_out,
  output logic [1:0] supply_brownout_monitor_action_out,
  output logic supply_brownout_monitor_hyst_out,
  // core brownout monitor
  output logic [8:0] core_brownout_monitor_cfg_out,
  // watchdog timer
  output logic watchdog_timer_en_out,
  output logic watchdog_timer_always_on_out,
  output logic [3:0] watchdog_timer_period_out,
  output logic [3:0] watchdog_timer_window_out,
  output logic [3:0] early_warning_offset_out,
  output logic watchdog_timer_window_en_out
);

  cfg_loader_pkg::load_st_t state_r;
  logic [2:0] settle_r;
  logic [63:0] user_r;
  logic [63:0] cal_r;
  logic ack_r;
  logic [31:0] rdata_nxt;
  logic [63:0] merge_nxt;
  logic req;

  // -------- power-on load sequence --------
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_r <= cfg_loader_pkg::ST_SETTLE;
      settle_r <= 3'h0;
    end else begin
      unique case (state_r)
        cfg_loader_pkg::ST_SETTLE: begin
          settle_r <= settle_r + 3'h1;
          if (settle_r == cfg_loader_pkg::LOAD_CYCLES - 3'h1) begin
            state_r <= cfg_loader_pkg::ST_USER;
          end
        end
        cfg_loader_pkg::ST_USER: state_r <= cfg_loader_pkg::ST_CAL;
        cfg_loader_pkg::ST_CAL: state_r <= cfg_loader_pkg::ST_DONE;
        cfg_loader_pkg::ST_DONE: state_r <= cfg_loader_pkg::ST_DONE;
      endcase
    end
  end

  // R02: user row captured once per reset, no software needed
  // R04: later array changes wait for the next reset
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      user_r <= {cfg_loader_pkg::LOCK_DEF, 6'h00,
                 1'h0, cfg_loader_pkg::SUP_HYS_DEF,
                 1'h0, cfg_loader_pkg::WD_EW_DEF, cfg_loader_pkg::WD_WIN_DEF,
                 cfg_loader_pkg::WD_PER_DEF, 2'h0,
                 cfg_loader_pkg::CORE_DEF, cfg_loader_pkg::SUP_ACT_DEF,
                 cfg_loader_pkg::SUP_EN_DEF, cfg_loader_pkg::SUP_LVL_DEF,
                 1'h0, cfg_loader_pkg::EEP_DEF, 1'h0,
                 WAFER_PKG ? cfg_loader_pkg::BOOT_DEF_WLP
                           : cfg_loader_pkg::BOOT_DEF};
    end else if (state_r == cfg_loader_pkg::ST_USER) begin
      user_r <= user_row_array_in;
    end
  end

  // R01: automatic calibration row copied at startup
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cal_r <= 64'h0000000000000000;
    end else if (state_r == cfg_loader_pkg::ST_CAL) begin
      cal_r <= auto_cal_array_in;
    end
  end

  // R20: consumers leave reset only once every field is in place
  assign load_done_out = (state_r == cfg_loader_pkg::ST_DONE);
  assign consumer_rstn_out = load_done_out;
  assign auto_cal_out = cal_r;

  // R05: bootloader size; bit 3 unused
  assign bootloader_region_size_out = user_r[cfg_loader_pkg::BOOT_LSB +: 3];
  // R06: eeprom size; bit 7 unused
  assign eeprom_size_out = user_r[cfg_loader_pkg::EEP_LSB +: 3];
  // R07: supply monitor level and enable
  assign supply_brownout_monitor_level_out =
    user_r[cfg_loader_pkg::SUP_LVL_LSB +: 6];
  assign supply_brownout_monitor_en_out = user_r[cfg_loader_pkg::SUP_EN_BIT];
  // R08: supply monitor action and hysteresis
  assign supply_brownout_monitor_action_out =
    user_r[cfg_loader_pkg::SUP_ACT_LSB +: 2];
  assign supply_brownout_monitor_hyst_out =
    user_r[cfg_loader_pkg::SUP_HYS_BIT];
  assign core_brownout_monitor_cfg_out = {user_r[cfg_loader_pkg::CORE_HI_BIT],
                                          user_r[cfg_loader_pkg::CORE_LSB +: 8]};
  // R10: watchdog enable and always-on
  assign watchdog_timer_en_out = user_r[cfg_loader_pkg::WD_EN_BIT];
  assign watchdog_timer_always_on_out = user_r[cfg_loader_pkg::WD_AON_BIT];
  // R11: watchdog period and window
  assign watchdog_timer_period_out = user_r[cfg_loader_pkg::WD_PER_LSB +: 4];
  assign watchdog_timer_window_out = user_r[cfg_loader_pkg::WD_WIN_LSB +: 4];
  // R12: early warning and window enable
  assign early_warning_offset_out = user_r[cfg_loader_pkg::WD_EW_LSB +: 4];
  assign watchdog_timer_window_en_out = user_r[cfg_loader_pkg::WD_WEN_BIT];
  // R13: region locks; 47:42 unused
  assign region_lock_out = user_r[cfg_loader_pkg::LOCK_LSB +: 16];

  // -------- avalon slave --------
  // every access answers one cycle after it is raised
  assign req = avs_read_in | avs_write_in;
  assign avs_waitrequest_out = req & ~ack_r;

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  always_comb begin
    rdata_nxt = 32'h00000000;
    unique case (avs_address_in)
      // R03: live array content, not the loaded copy
      cfg_loader_pkg::ADDR_USER_LO: rdata_nxt = user_row_array_in[31:0];
      cfg_loader_pkg::ADDR_USER_HI: rdata_nxt = user_row_array_in[63:32];
      cfg_loader_pkg::ADDR_STATUS:
        rdata_nxt = {30'h00000000, user_row_array_in != user_r,
                     load_done_out};
      // R16: converter trims pass straight through
      cfg_loader_pkg::ADDR_FCAL_W0: rdata_nxt = factory_cal_array_in[31:0];
      // R17: only bits up to 63 carry trims, the rest read zero
      cfg_loader_pkg::ADDR_FCAL_W1: rdata_nxt = factory_cal_array_in[63:32];
      cfg_loader_pkg::ADDR_FCAL_W2: rdata_nxt = 32'h00000000;
      cfg_loader_pkg::ADDR_FCAL_W3: rdata_nxt = 32'h00000000;
      // R18: serial words in word order
      cfg_loader_pkg::ADDR_SERIAL_W0: rdata_nxt = serial_array_in[31:0];
      cfg_loader_pkg::ADDR_SERIAL_W1: rdata_nxt = serial_array_in[63:32];
      cfg_loader_pkg::ADDR_SERIAL_W2: rdata_nxt = serial_array_in[95:64];
      cfg_loader_pkg::ADDR_SERIAL_W3: rdata_nxt = serial_array_in[127:96];
      default: rdata_nxt = 32'h00000000;
    endcase
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      avs_readdata_out <= 32'h00000000;
    end else if (avs_read_in & ~ack_r) begin
      avs_readdata_out <= rdata_nxt;
    end
  end

  // write image: byte merge over the current array content
  always_comb begin
    merge_nxt = user_row_array_in;
    for (int b = 0; b < 4; b++) begin
      if (avs_byteenable_in[b]) begin
        if (avs_address_in == cfg_loader_pkg::ADDR_USER_HI) begin
          merge_nxt[32 + 8 * b +: 8] = avs_writedata_in[8 * b +: 8];
        end else begin
          merge_nxt[8 * b +: 8] = avs_writedata_in[8 * b +: 8];
        end
      end
    end
    // R09: production core monitor bits are never overwritten
    merge_nxt[cfg_loader_pkg::CORE_LSB +: 8] =
      user_row_array_in[cfg_loader_pkg::CORE_LSB +: 8];
    merge_nxt[cfg_loader_pkg::CORE_HI_BIT] =
      user_row_array_in[cfg_loader_pkg::CORE_HI_BIT];
  end

  // R14: only user row words start a write; other targets drop it
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      user_row_wr_out <= 1'b0;
      user_row_wr_data_out <= 64'h0000000000000000;
    end else begin
      user_row_wr_out <= 1'b0;
      if (avs_write_in & ack_r &
          ((avs_address_in == cfg_loader_pkg::ADDR_USER_LO) |
           (avs_address_in == cfg_loader_pkg::ADDR_USER_HI))) begin
        user_row_wr_out <= 1'b1;
        user_row_wr_data_out <= merge_nxt;
      end
    end
  end

endmodule : cfg_loader

// ===== cfg_loader_pkg.sv
// Behaviour
// R01: at startup copy every automatic calibration row value to its owner
// R02: at power-on read the user row and apply fields without software
// R03: user row readable by software at its fixed system address
// R04: rewritten user row reaches consumers only after the next reset
// R05: bits 2:0 bootloader protection size, default 7 or 3; bit 3 reserved
// R06: bits 6:4 emulated EEPROM size, default 7; bit 7 reserved
// R07: supply monitor threshold bits 13:8 (0x22), enable bit 14 (1)
// R08: supply monitor action bits 16:15 (1), hysteresis bit 40 (0)
// R09: writers keep core monitor bits 24:17 (0x70) and bit 41 unchanged
// R10: watchdog enable bit 25 and always-on bit 26, both default 0
// R11: watchdog period bits 30:27 (0x0B), window time-out bits 34:31 (0x05)
// R12: watchdog early warning bits 38:35 (0x0B), window enable bit 39 (0)
// R13: bits 63:48 region locks, default 0xFFFF; bits 47:42 reserved
// R14: factory calibration readable at fixed address, writes ignored
// R15: software copies factory calibration values into module registers
// R16: factory area gives converter linearity 34:27 and bias 37:35
// R17: slow oscillator trim 44:38, loop coarse trim 63:58; rest reserved
// R18: 128-bit serial number as four read-only words at fixed addresses
// R19: software must use all four serial words for uniqueness
// R20: all fields distributed before consumer reset is released
package cfg_loader_pkg;
  // bus byte addresses
  localparam logic [23:0] ADDR_USER_LO = 24'h804000;
  localparam logic [23:0] ADDR_USER_HI = 24'h804004;
  localparam logic [23:0] ADDR_STATUS = 24'h804100;
  localparam logic [23:0] ADDR_FCAL_W0 = 24'h806020;
  localparam logic [23:0] ADDR_FCAL_W1 = 24'h806024;
  localparam logic [23:0] ADDR_FCAL_W2 = 24'h806028;
  localparam logic [23:0] ADDR_FCAL_W3 = 24'h80602C;
  localparam logic [23:0] ADDR_SERIAL_W0 = 24'h80A00C;
  localparam logic [23:0] ADDR_SERIAL_W1 = 24'h80A040;
  localparam logic [23:0] ADDR_SERIAL_W2 = 24'h80A044;
  localparam logic [23:0] ADDR_SERIAL_W3 = 24'h80A048;
  // user row field positions
  localparam int BOOT_LSB = 0;
  localparam int EEP_LSB = 4;
  localparam int SUP_LVL_LSB = 8;
  localparam int SUP_EN_BIT = 14;
  localparam int SUP_ACT_LSB = 15;
  localparam int CORE_LSB = 17;
  localparam int WD_EN_BIT = 25;
  localparam int WD_AON_BIT = 26;
  localparam int WD_PER_LSB = 27;
  localparam int WD_WIN_LSB = 31;
  localparam int WD_EW_LSB = 35;
  localparam int WD_WEN_BIT = 39;
  localparam int SUP_HYS_BIT = 40;
  localparam int CORE_HI_BIT = 41;
  localparam int LOCK_LSB = 48;
  // defaults before the first load
  localparam logic [2:0] BOOT_DEF = 3'h7;
  localparam logic [2:0] BOOT_DEF_WLP = 3'h3;
  localparam logic [2:0] EEP_DEF = 3'h7;
  localparam logic [5:0] SUP_LVL_DEF = 6'h22;
  localparam logic SUP_EN_DEF = 1'h1;
  localparam logic [1:0] SUP_ACT_DEF = 2'h1;
  localparam logic SUP_HYS_DEF = 1'h0;
  localparam logic [7:0] CORE_DEF = 8'h70;
  localparam logic [3:0] WD_PER_DEF = 4'hB;
  localparam logic [3:0] WD_WIN_DEF = 4'h5;
  localparam logic [3:0] WD_EW_DEF = 4'hB;
  localparam logic [15:0] LOCK_DEF = 16'hFFFF;
  // factory calibration field positions
  localparam int ADC_LIN_LSB = 27;
  localparam int ADC_BIAS_LSB = 35;
  localparam int OSC_TRIM_LSB = 38;
  localparam int LOOP_TRIM_LSB = 58;
  localparam int FCAL_USED_MSB = 63;
  // array read settle time before capture
  localparam logic [2:0] LOAD_CYCLES = 3'h4;
  typedef enum logic [1:0] {ST_SETTLE, ST_USER, ST_CAL, ST_DONE} load_st_t;
endpackage : cfg_loader_pkg

// ===== cfg_loader_assertions.sv
`timescale 1ns/1ps
module cfg_loader_assertions (
  // bus
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic avs_waitrequest_out,
  // arrays and load
  input wire logic [63:0] user_row_array_in,
  input wire logic [63:0] auto_cal_array_in,
  input wire logic user_row_wr_out,
  input wire logic [63:0] user_row_wr_data_out,
  input wire logic load_done_out,
  input wire logic consumer_rstn_out,
  input wire logic [63:0] auto_cal_out,
  // sampled fields
  input wire logic [5:0] supply_brownout_monitor_level_out,
  input wire logic [3:0] watchdog_timer_period_out,
  input wire logic [15:0] region_lock_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);
  one_wait_a: assert property ((avs_read_in | avs_write_in) &&
    avs_waitrequest_out |=> !avs_waitrequest_out) else $error("bus stall");
  idle_nowait_a: assert property (!(avs_read_in | avs_write_in)
    |-> !avs_waitrequest_out) else $error("wait without request");
  load_time_a: assert property ($rose(rstn_in) |->
    !load_done_out [*6] ##1 load_done_out) else $error("load timing");
  rst_hold_a: assert property ($rose(consumer_rstn_out) |->
    auto_cal_out == auto_cal_array_in &&
    region_lock_out == user_row_array_in[63:48])
    else $error("consumer reset early");
  cal_copy_a: assert property (load_done_out |->
    auto_cal_out == auto_cal_array_in) else $error("auto cal not copied");
  field_load_a: assert property ($rose(load_done_out) |->
    supply_brownout_monitor_level_out == user_row_array_in[13:8] &&
    watchdog_timer_period_out == user_row_array_in[30:27] &&
    region_lock_out == user_row_array_in[63:48]) else $error("field load");
  hold_fields_a: assert property (load_done_out && $past(load_done_out)
    |-> $stable({supply_brownout_monitor_level_out,
    watchdog_timer_period_out, region_lock_out})) else $error("field moved");
  wr_pulse_a: assert property (user_row_wr_out |=> !user_row_wr_out)
    else $error("program pulse too long");
  core_keep_a: assert property (user_row_wr_out |->
    user_row_wr_data_out[24:17] == user_row_array_in[24:17] &&
    user_row_wr_data_out[41] == user_row_array_in[41]) else $error("core");
endmodule : cfg_loader_assertions

// ===== nvm_array_model.sv
`timescale 1ns/1ps
module nvm_array_model #(
  parameter logic [63:0] USER_INIT = 64'h0,
  parameter logic [63:0] AUTO_INIT = 64'h0,
  parameter logic [127:0] FCAL_INIT = 128'h0,
  parameter logic [127:0] SER_INIT = 128'h0
) (
  input wire logic mclk_in,
  input wire logic prog_in,
  input wire logic [63:0] prog_data_in,
  output logic [63:0] user_row_out,
  output logic [63:0] auto_cal_out,
  output logic [127:0] factory_cal_out,
  output logic [127:0] serial_out
);
  initial user_row_out = USER_INIT;
  // image stored whole; a bad image would reach the fields after reset
  always @(posedge mclk_in) if (prog_in) user_row_out <= prog_data_in;
  assign auto_cal_out = AUTO_INIT;
  assign factory_cal_out = FCAL_INIT;
  assign serial_out = SER_INIT;
endmodule : nvm_array_model

// ===== tb_top.sv
`timescale 1ns/1ps
module tb_top;
  localparam logic [63:0] UR = 64'h5A3C_01A9_74E0_9B65;
  localparam logic [63:0] AC = 64'h0F1E_2D3C_4B5A_6978;
  localparam logic [127:0] FC = 128'h1111_2222_3333_4444_89AB_CDEF_0123_4567;
  localparam logic [127:0] SN = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
  // defaults packed as a user row image
  localparam logic [63:0] DEF = 64'hFFFF_005A_D8E0_E277;
  logic mclk_in = 0, rstn_in, rd = 0, wr = 0;
  logic [23:0] addr = '0;
  logic [31:0] wd = '0, rdq, rdata;
  logic [3:0] be = '0;
  logic [63:0] ua, aa, wimg, acal, u1, u2;
  logic [127:0] fa, sa;
  logic wq, wrp, done, crst, sen, hys, wden, aon, wwen;
  logic [2:0] boot, eep, bootw;
  logic [15:0] lock;
  logic [5:0] lvl;
  logic [1:0] act;
  logic [8:0] core;
  logic [3:0] per, win, ew;
  int error_cnt = 0, n_tests = 0, cyc = 0;
  cfg_loader cfg_loader_i (.mclk_in(mclk_in), .rstn_in(rstn_in),
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wd), .avs_byteenable_in(be), .avs_readdata_out(rdq),
    .avs_waitrequest_out(wq), .user_row_array_in(ua),
    .auto_cal_array_in(aa), .factory_cal_array_in(fa), .serial_array_in(sa),
    .user_row_wr_out(wrp), .user_row_wr_data_out(wimg),
    .load_done_out(done), .consumer_rstn_out(crst), .auto_cal_out(acal),
    .bootloader_region_size_out(boot), .eeprom_size_out(eep),
    .region_lock_out(lock), .supply_brownout_monitor_level_out(lvl),
    .supply_brownout_monitor_en_out(sen),
    .supply_brownout_monitor_action_out(act),
    .supply_brownout_monitor_hyst_out(hys),
    .core_brownout_monitor_cfg_out(core), .watchdog_timer_en_out(wden),
    .watchdog_timer_always_on_out(aon), .watchdog_timer_period_out(per),
    .watchdog_timer_window_out(win), .early_warning_offset_out(ew),
    .watchdog_timer_window_en_out(wwen));
  // wafer-level package build: only its bootloader default differs
  cfg_loader #(.WAFER_PKG(1'b1)) cfg_loader_wlp_i (.mclk_in(mclk_in),
    .rstn_in(rstn_in), .avs_address_in(addr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(be),
    .avs_readdata_out(), .avs_waitrequest_out(), .user_row_array_in(ua),
    .auto_cal_array_in(aa), .factory_cal_array_in(fa), .serial_array_in(sa),
    .user_row_wr_out(), .user_row_wr_data_out(), .load_done_out(),
    .consumer_rstn_out(), .auto_cal_out(),
    .bootloader_region_size_out(bootw), .eeprom_size_out(),
    .region_lock_out(), .supply_brownout_monitor_level_out(),
    .supply_brownout_monitor_en_out(),
    .supply_brownout_monitor_action_out(),
    .supply_brownout_monitor_hyst_out(), .core_brownout_monitor_cfg_out(),
    .watchdog_timer_en_out(), .watchdog_timer_always_on_out(),
    .watchdog_timer_period_out(), .watchdog_timer_window_out(),
    .early_warning_offset_out(), .watchdog_timer_window_en_out());
  nvm_array_model #(.USER_INIT(UR), .AUTO_INIT(AC), .FCAL_INIT(FC),
    .SER_INIT(SN)) nvm_array_model_i (.mclk_in(mclk_in), .prog_in(wrp),
    .prog_data_in(wimg), .user_row_out(ua), .auto_cal_out(aa),
    .factory_cal_out(fa), .serial_out(sa));
  initial forever #4 mclk_in = ~mclk_in;
  task report_and_stop;
    $display("errors %0d checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  // hang guard, well above the roughly one hundred cycles the run needs
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      report_and_stop;
    end
  end
  task chk(input string nm, input logic [127:0] seen, input logic [127:0] e);
    n_tests++;
    if (seen !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, seen);
    end
  endtask : chk
  task bus(input logic w, input logic [23:0] a, input logic [31:0] d,
    input logic [3:0] b);
    @(posedge mclk_in);
    rd <= !w; wr <= w; addr <= a; wd <= d; be <= b;
    do @(posedge mclk_in); while (wq !== 1'b0);
    rdata = rdq;
    rd <= 1'b0; wr <= 1'b0;
  endtask : bus
  task rchk(input logic [23:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'h0);
    chk($sformatf("read %h", a), rdata, e);
  endtask : rchk
  task fields(input logic [63:0] u);
    chk("nvm", {boot, eep, lock}, {u[2:0], u[6:4], u[63:48]});
    chk("supply", {lvl, sen, act, hys}, {u[13:8], u[14], u[16:15], u[40]});
    chk("core", core, {u[41], u[24:17]});
    chk("wdt", {wwen, ew, win, per, aon, wden}, u[39:25]);
  endtask : fields
  task reload;
    rstn_in <= 1'b0;
    repeat (12) @(posedge mclk_in);
    rstn_in <= 1'b1;
    for (int i = 0; i < 20 && done !== 1'b1; i++) @(posedge mclk_in);
    chk("done", {done, crst}, 2'b11);
    chk("auto", acal, AC);
  endtask : reload
  task t_user;
    rchk(cfg_loader_pkg::ADDR_USER_LO, UR[31:0]);
    rchk(cfg_loader_pkg::ADDR_USER_HI, UR[63:32]);
    bus(1'b1, cfg_loader_pkg::ADDR_USER_LO, 32'hC3FE_D2B1, 4'hF);
    #1;
    u1 = {UR[63:32], 7'h61, UR[24:17], 17'h0D2B1};
    chk("img lo", {wrp, wimg}, {1'b1, u1});
    bus(1'b1, cfg_loader_pkg::ADDR_USER_HI, 32'h0077_EE00, 4'h6);
    #1;
    u2 = {u1[63:56], 8'h77, 8'hEC, u1[39:0]};
    u2[41] = u1[41];
    chk("img hi", {wrp, wimg}, {1'b1, u2});
    fields(UR);
    rchk(cfg_loader_pkg::ADDR_USER_HI, u2[63:32]);
    rchk(cfg_loader_pkg::ADDR_STATUS, 32'h3);
    reload;
    fields(u2);
    rchk(cfg_loader_pkg::ADDR_STATUS, 32'h1);
  endtask : t_user
  task t_cal_serial;
    // software pulls each factory word itself
    for (int i = 0; i < 4; i++)
      rchk(cfg_loader_pkg::ADDR_FCAL_W0 + 24'(4 * i),
        i < 2 ? FC[32 * i +: 32] : 32'h0);
    bus(1'b1, cfg_loader_pkg::ADDR_FCAL_W1, 32'hFFFF_FFFF, 4'hF);
    #1;
    chk("ro write", wrp, 1'b0);
    rchk(cfg_loader_pkg::ADDR_FCAL_W1, FC[63:32]);
    rchk(cfg_loader_pkg::ADDR_SERIAL_W0, SN[31:0]);
    rchk(cfg_loader_pkg::ADDR_SERIAL_W1, SN[63:32]);
    rchk(cfg_loader_pkg::ADDR_SERIAL_W2, SN[95:64]);
    rchk(cfg_loader_pkg::ADDR_SERIAL_W3, SN[127:96]);
    rchk(24'h804200, 32'h0);
  endtask : t_cal_serial
  initial begin
    // x to 0 gives the asynchronous reset a real falling edge
    rstn_in <= 1'b0;
    repeat (12) @(posedge mclk_in);
    fields(DEF);
    chk("boot wlp", bootw, 3'h3);
    reload;
    fields(UR);
    t_user;
    t_cal_serial;
    report_and_stop;
  end
endmodule : tb_top
bind cfg_loader cfg_loader_assertions cfg_loader_assertions_i (
  .mclk_in(mclk_in), .rstn_in(rstn_in), .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in), .avs_waitrequest_out(avs_waitrequest_out),
  .user_row_array_in(user_row_array_in),
  .auto_cal_array_in(auto_cal_array_in), .user_row_wr_out(user_row_wr_out),
  .user_row_wr_data_out(user_row_wr_data_out), .load_done_out(load_done_out),
  .consumer_rstn_out(consumer_rstn_out), .auto_cal_out(auto_cal_out),
  .supply_brownout_monitor_level_out(supply_brownout_monitor_level_out),
  .watchdog_timer_period_out(watchdog_timer_period_out),
  .region_lock_out(region_lock_out));
